/* File: hold_timer.sv */
`timescale 1ns/1ns
module hold_timer
  import supervisor_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cond,
  input wire logic freeze,
  input wire logic [31:0] tmo_cyc,
  output logic active
);

  typedef struct packed {
    logic active;
    logic [31:0] cnt;
  } hold_state_t;

  hold_state_t st_r;
  hold_state_t st_nxt;

  // ---------------------------------------------------------------
  // Assert on the condition, release only after a full quiet timeout
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (freeze) begin
      st_nxt = st_r;
    end else if (cond) begin
      st_nxt.active = 1'b1; // RULE12
      st_nxt.cnt = '0; // RULE27
    end else if (st_r.active) begin
      if (st_r.cnt + 32'h0000_0001 >= tmo_cyc) begin
        st_nxt.active = 1'b0; // RULE19
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      end
    end
  end

  // Reset counts as a start condition, so every output powers up active.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{active: 1'b1, cnt: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.active;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_cond_asserts: assert property (cond && !freeze |=> active) // RULE12
    else $error("Output not active one cycle after its condition.");
  chk_hold_release: assert property (
    active && !cond && !freeze && (st_r.cnt + 32'h0000_0001 < tmo_cyc) |=> active) // RULE19
    else $error("Output released before its timeout expired.");

endmodule // hold_timer

/* File: host_model.sv */
`timescale 1ns/1ns
module host_model
  import supervisor_pkg::*;
(
  input wire logic clk,
  output reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] rng = 8'h00;
  initial reg_req = '0;
  // ---------------------------------------------------------------
  // Code limits
  // ---------------------------------------------------------------
  // Larger codes would push a threshold past what the input can stand, so they are cut down.
  function automatic logic [7:0] lim(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = 8'hff;
    if (a == 8'h00 && !rng[0]) m = 8'hd6;
    if (a == 8'h01) m = rng[6] ? 8'h48 : 8'h3c;
    if (a >= 8'h02 && a <= 8'h05 && !rng[a[2:0]-3'h1]) m = 8'he1;
    return (d > m) ? m : d;
  endfunction
  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    if (a == ADDR_RANGE) rng = d;
    reg_req.addr = a;
    reg_req.wdata = lim(a, d);
    reg_req.wr = 1'b1;
    @(posedge clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge clk);
    #1;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
    d = reg_rdata;
  endtask
endmodule // host_model

/* File: supervisor_pkg.sv */
package supervisor_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int N_DET = 6;
  localparam int N_PO = 8;
  localparam int N_GPI = 4;
  localparam int N_TMO = 7;
  localparam int N_WD = 8;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_THR_BASE = 8'h00;
  localparam logic [7:0] ADDR_THR_LAST = 8'h05;
  localparam logic [7:0] ADDR_RANGE = 8'h0d;
  localparam logic [7:0] ADDR_GPI_POL = 8'h3b;
  localparam logic [7:0] ADDR_MR_SEL = 8'h40;
  localparam int RNG_HV_BIT = 0;
  localparam int RNG_POS_LO = 1;
  localparam int RNG_UNUSED_BIT = 5;
  localparam int RNG_SEC_LO = 6;
  localparam int RNG_SEC_HI = 7;
  localparam logic [7:0] RST_THR = 8'h00;
  localparam logic [7:0] RST_RANGE = 8'h00;
  localparam logic [3:0] RST_GPI_POL = 4'h0;
  localparam logic [7:0] RST_MR_SEL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // Threshold arithmetic in millivolts, class 0 high-voltage, 1 second, 2 positive
  // ---------------------------------------------------------------
  localparam logic [15:0] WIDE_BASE_MV [3] = '{16'h09c4, 16'h09c4, 16'h03e8};
  localparam logic [15:0] WIDE_STEP_MV [3] = '{16'h0032, 16'h0032, 16'h0014};
  localparam logic [15:0] FINE_BASE_MV [3] = '{16'h04e2, 16'h04e2, 16'h01f4};
  localparam logic [15:0] FINE_STEP_MV [3] = '{16'h0019, 16'h0019, 16'h000a};
  localparam logic [15:0] HV_FINE_MAX_MV = 16'h1dc9;
  localparam logic [15:0] POS_FINE_MAX_MV = 16'h0bea;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint T_PO_NS [N_TMO] = '{25_000, 1_562_500, 6_250_000, 50_000_000,
                                         200_000_000, 400_000_000, 1_600_000_000};
  localparam longint T_WD_NS [N_WD] = '{6_250_000, 25_000_000, 100_000_000, 400_000_000,
                                        1_600_000_000, 6_400_000_000, 25_600_000_000, 102_400_000_000};

  function automatic logic [31:0] cyc_up(input longint ns);
    return 32'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam logic [N_TMO-1:0][31:0] PO_TMO_CYC_DEF = {
    cyc_up(T_PO_NS[6]), cyc_up(T_PO_NS[5]), cyc_up(T_PO_NS[4]), cyc_up(T_PO_NS[3]),
    cyc_up(T_PO_NS[2]), cyc_up(T_PO_NS[1]), cyc_up(T_PO_NS[0])};
  localparam logic [N_WD-1:0][31:0] WD_CYC_DEF = {
    cyc_up(T_WD_NS[7]), cyc_up(T_WD_NS[6]), cyc_up(T_WD_NS[5]), cyc_up(T_WD_NS[4]),
    cyc_up(T_WD_NS[3]), cyc_up(T_WD_NS[2]), cyc_up(T_WD_NS[1]), cyc_up(T_WD_NS[0])};

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WD_CLR_GPI_AND_PO, WD_CLR_GPI, WD_CLR_PO} wd_clr_t;
  typedef enum logic [1:0] {WD_OFF, WD_FIRST, WD_NORMAL} wd_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic active_high;
    logic [N_DET-1:0] det_mask;
    logic [N_GPI-1:0] gpi_mask;
    logic wd_mask;
    logic [N_PO-1:0] po_mask;
    logic [2:0] tmo_sel;
  } po_cfg_t;

  typedef struct packed {
    logic enable;
    wd_clr_t clr_src;
    logic [1:0] gpi_idx;
    logic [2:0] po_idx;
    logic [2:0] init_sel;
    logic [2:0] norm_sel;
  } wd_cfg_t;

  typedef struct packed {
    logic wr_block_en;
    logic [2:0] wr_block_po;
    logic cfg_lock;
  } nv_cfg_t;

endpackage

/* File: supply_supervisor.sv */
// Overview of operation
// [RULE1] Each detector reads its own threshold byte.
// [RULE2] One shared register selects all detector ranges.
// [RULE3] High-voltage wide range: 2.5V plus 50mV steps.
// [RULE4] High-voltage fine range: 1.25V plus 25mV steps.
// [RULE5] Host keeps high-voltage wide code at most 214.
// [RULE6] Second input: 2.5V/50mV wide, 1.25V/25mV fine.
// [RULE7] Host keeps second code within 60 or 72.
// [RULE8] Positive inputs wide range: 1V plus 20mV steps.
// [RULE9] Positive inputs fine range: 0.5V plus 10mV steps.
// [RULE10] Host keeps positive wide code at most 225.
// [RULE11] Fault flagged when input falls below threshold.
// [RULE12] Outputs have polarity and selectable dependency sources.
// [RULE13] Output timeout chosen from seven fixed periods.
// [RULE14] Logic inputs have configurable sense, feed outputs, watchdog.
// [RULE15] Watchdog cleared by input, output, or both.
// [RULE16] First watchdog period chosen from eight values.
// [RULE17] Later watchdog period chosen independently, same values.
// [RULE18] Manual reset low forces following outputs active.
// [RULE19] After manual reset, release waits own timeout.
// [RULE20] Manual reset alone never drives an output.
// [RULE21] Selected output state blocks user memory writes.
// [RULE22] Range bit 0 picks high-voltage range.
// [RULE23] Range bits 7:6 pick second range, 0x unused.
// [RULE24] Range bits 1..4 pick positive input ranges.
// [RULE25] Threshold registers follow input order from 00h.
// [RULE26] Codes unsigned; changes apply at next comparison.
// [RULE27] All timeouts counted from one clock, restartable.
`timescale 1ns/1ns
module supply_supervisor
  import supervisor_pkg::*;
#(
  parameter logic [N_TMO-1:0][31:0] PO_TMO_CYC = PO_TMO_CYC_DEF,
  parameter logic [N_WD-1:0][31:0] WD_CYC = WD_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [N_DET-1:0][15:0] det_level_mv,
  input wire logic [N_GPI-1:0] gpi_pin,
  input wire logic manual_reset_n,
  input wire logic margin_n,
  input wire po_cfg_t [N_PO-1:0] po_cfg,
  input wire wd_cfg_t wd_cfg,
  input wire nv_cfg_t nv_cfg,
  output logic [N_PO-1:0] po_od_out,
  output logic [N_PO-1:0] po_od_oe_n,
  output logic [N_PO-1:0] po_active,
  output logic [N_DET-1:0] det_uv,
  output logic watchdog_fault,
  output logic user_nv_wr_block,
  output logic cfg_nv_wr_block
);

  typedef struct packed {
    logic [N_DET-1:0][7:0] thr;
    logic [7:0] rng;
    logic [N_GPI-1:0] gpi_pol;
    logic [N_PO-1:0] mr_sel;
    logic [1:0] mr_sync;
    logic [1:0] margin_sync;
    logic [N_GPI-1:0] gpi_s1;
    logic [N_GPI-1:0] gpi_s2;
    logic [N_DET-1:0] uv;
    logic [7:0] rdata;
    wd_state_t wd_st;
    logic [31:0] wd_cnt;
    logic wd_fault;
    logic wd_src_prev;
    logic [N_PO-1:0] pin_oe_n;
    logic user_blk;
    logic cfg_blk;
  } sup_state_t;

  sup_state_t st_r;
  sup_state_t st_nxt;

  wire logic [N_DET-1:0] det_fine;
  wire logic [N_DET-1:0] det_en;
  wire logic [N_DET-1:0][15:0] thr_mv;
  wire logic [N_DET-1:0] uv_now;
  wire logic [N_PO-1:0] po_act;
  wire logic [N_PO-1:0] po_cond;
  wire logic [N_PO-1:0] has_other;
  wire logic [N_GPI-1:0] gpi_act;
  wire logic mr_act;
  wire logic margin_hold;

  // ---------------------------------------------------------------
  // Synchronised pins
  // ---------------------------------------------------------------
  assign gpi_act = ~(st_r.gpi_s2 ^ st_r.gpi_pol); // RULE14
  assign mr_act = ~st_r.mr_sync[1];
  assign margin_hold = ~st_r.margin_sync[1];

  // ---------------------------------------------------------------
  // Threshold decode and undervoltage compare
  // ---------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < N_DET; gi++) begin : g_det
    localparam int CLS = (gi < 2) ? gi : 2;
    if (gi == 0) begin : g_hv
      assign det_fine[gi] = st_r.rng[RNG_HV_BIT]; // RULE22
      assign det_en[gi] = 1'b1;
    end else if (gi == 1) begin : g_sec
      assign det_fine[gi] = st_r.rng[RNG_SEC_LO]; // RULE23
      assign det_en[gi] = st_r.rng[RNG_SEC_HI]; // RULE23
    end else begin : g_pos
      assign det_fine[gi] = st_r.rng[RNG_POS_LO + gi - 2]; // RULE24
      assign det_en[gi] = 1'b1;
    end
    // Codes are unsigned bytes; the product always fits 16 bits for every class.
    assign thr_mv[gi] = det_fine[gi] ?
      16'({8'h00, st_r.thr[gi]} * FINE_STEP_MV[CLS]) + FINE_BASE_MV[CLS] : // RULE4 RULE6 RULE9
      16'({8'h00, st_r.thr[gi]} * WIDE_STEP_MV[CLS]) + WIDE_BASE_MV[CLS]; // RULE3 RULE6 RULE8
    assign uv_now[gi] = det_en[gi] && (det_level_mv[gi] < thr_mv[gi]); // RULE11 RULE26
  end

  // ---------------------------------------------------------------
  // Programmable output stages
  // ---------------------------------------------------------------
  for (gi = 0; gi < N_PO; gi++) begin : g_po
    logic [31:0] tmo_sel_cyc;
    assign has_other[gi] = (|po_cfg[gi].det_mask) | (|po_cfg[gi].gpi_mask) |
                           po_cfg[gi].wd_mask | (|po_cfg[gi].po_mask);
    // Manual reset only counts once some other source is chosen.
    assign po_cond[gi] = (|(st_r.uv & po_cfg[gi].det_mask)) |
                         (|(gpi_act & po_cfg[gi].gpi_mask)) |
                         (st_r.wd_fault & po_cfg[gi].wd_mask) |
                         (|(po_act & po_cfg[gi].po_mask)) | // RULE12
                         (mr_act & st_r.mr_sel[gi] & has_other[gi]); // RULE18 RULE20
    // An out-of-range select picks the longest period rather than none.
    assign tmo_sel_cyc = (po_cfg[gi].tmo_sel < 3'(N_TMO)) ?
                         PO_TMO_CYC[po_cfg[gi].tmo_sel] : PO_TMO_CYC[N_TMO-1]; // RULE13
    hold_timer u_hold (
      .clk(clk),
      .rst(rst),
      .cond(po_cond[gi]),
      .freeze(margin_hold),
      .tmo_cyc(tmo_sel_cyc),
      .active(po_act[gi])
    );
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  logic wd_src;
  logic wd_clr_evt;
  logic [31:0] wd_limit;
  logic wd_expire;

  always_comb begin
    unique case (wd_cfg.clr_src)
      WD_CLR_GPI_AND_PO: wd_src = gpi_act[wd_cfg.gpi_idx] & po_act[wd_cfg.po_idx]; // RULE15
      WD_CLR_GPI: wd_src = gpi_act[wd_cfg.gpi_idx]; // RULE15
      WD_CLR_PO: wd_src = po_act[wd_cfg.po_idx]; // RULE15
      default: wd_src = 1'b0;
    endcase
  end

  assign wd_clr_evt = wd_src & ~st_r.wd_src_prev;
  assign wd_limit = (st_r.wd_st == WD_FIRST) ? WD_CYC[wd_cfg.init_sel] : WD_CYC[wd_cfg.norm_sel]; // RULE16 RULE17
  assign wd_expire = (st_r.wd_st != WD_OFF) && (st_r.wd_cnt + 32'h0000_0001 >= wd_limit);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.mr_sync = {st_r.mr_sync[0], manual_reset_n};
    st_nxt.margin_sync = {st_r.margin_sync[0], margin_n};
    st_nxt.gpi_s1 = gpi_pin;
    st_nxt.gpi_s2 = st_r.gpi_s1;
    st_nxt.uv = uv_now; // RULE11

    if (reg_req.wr) begin
      if (reg_req.addr >= ADDR_THR_BASE && reg_req.addr <= ADDR_THR_LAST) begin
        st_nxt.thr[reg_req.addr[2:0]] = reg_req.wdata; // RULE1 RULE25
      end else if (reg_req.addr == ADDR_RANGE) begin
        st_nxt.rng = reg_req.wdata; // RULE2
        st_nxt.rng[RNG_UNUSED_BIT] = 1'b0;
      end else if (reg_req.addr == ADDR_GPI_POL) begin
        st_nxt.gpi_pol = reg_req.wdata[N_GPI-1:0]; // RULE14
      end else if (reg_req.addr == ADDR_MR_SEL) begin
        st_nxt.mr_sel = reg_req.wdata; // RULE18
      end
    end

    if (reg_req.rd) begin
      if (reg_req.addr >= ADDR_THR_BASE && reg_req.addr <= ADDR_THR_LAST) begin
        st_nxt.rdata = st_r.thr[reg_req.addr[2:0]];
      end else if (reg_req.addr == ADDR_RANGE) begin
        st_nxt.rdata = st_r.rng;
      end else if (reg_req.addr == ADDR_GPI_POL) begin
        st_nxt.rdata = {4'h0, st_r.gpi_pol};
      end else if (reg_req.addr == ADDR_MR_SEL) begin
        st_nxt.rdata = st_r.mr_sel;
      end else begin
        st_nxt.rdata = RD_UNMAPPED;
      end
    end

    st_nxt.wd_src_prev = wd_src;
    unique case (st_r.wd_st)
      WD_OFF: begin
        st_nxt.wd_fault = 1'b0;
        st_nxt.wd_cnt = '0;
        if (wd_cfg.enable) begin
          st_nxt.wd_st = WD_FIRST; // RULE16
        end
      end
      WD_FIRST, WD_NORMAL: begin
        if (!wd_cfg.enable) begin
          st_nxt.wd_st = WD_OFF;
          st_nxt.wd_fault = 1'b0;
          st_nxt.wd_cnt = '0;
        end else begin
          // An expiry in the same cycle as a clear keeps the fault set.
          st_nxt.wd_fault = wd_expire | (st_r.wd_fault & ~wd_clr_evt);
          if (wd_expire || wd_clr_evt) begin
            st_nxt.wd_cnt = '0; // RULE27
            st_nxt.wd_st = WD_NORMAL; // RULE17
          end else begin
            st_nxt.wd_cnt = st_r.wd_cnt + 32'h0000_0001;
          end
        end
      end
    endcase

    st_nxt.pin_oe_n = ~(po_act ^ {po_cfg[7].active_high, po_cfg[6].active_high,
                                  po_cfg[5].active_high, po_cfg[4].active_high,
                                  po_cfg[3].active_high, po_cfg[2].active_high,
                                  po_cfg[1].active_high, po_cfg[0].active_high}); // RULE12
    st_nxt.user_blk = nv_cfg.wr_block_en & po_act[nv_cfg.wr_block_po]; // RULE21
    st_nxt.cfg_blk = nv_cfg.cfg_lock;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Outputs pull low from reset, the same as a supply that is still coming up.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{thr: {N_DET{RST_THR}}, rng: RST_RANGE, gpi_pol: RST_GPI_POL,
                mr_sel: RST_MR_SEL, mr_sync: 2'h3, margin_sync: 2'h3,
                gpi_s1: 4'h0, gpi_s2: 4'h0, uv: 6'h00, rdata: 8'h00,
                wd_st: WD_OFF, wd_cnt: 32'h0000_0000, wd_fault: 1'b0,
                wd_src_prev: 1'b0, pin_oe_n: 8'h00, user_blk: 1'b0, cfg_blk: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign po_od_out = '0;
  assign po_od_oe_n = st_r.pin_oe_n;
  assign po_active = po_act;
  assign det_uv = st_r.uv;
  assign watchdog_fault = st_r.wd_fault;
  assign user_nv_wr_block = st_r.user_blk;
  assign cfg_nv_wr_block = st_r.cfg_blk;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_first_expiry;
    st_r.wd_st == WD_FIRST && wd_cfg.enable && !wd_clr_evt &&
      st_r.wd_cnt + 32'h0000_0001 == WD_CYC[wd_cfg.init_sel];
  endsequence

  sequence s_clear_only;
    st_r.wd_st != WD_OFF && wd_cfg.enable && wd_clr_evt && !wd_expire;
  endsequence

  chk_thr_write_lands: assert property ( // RULE25
    reg_req.wr && reg_req.addr == ADDR_THR_BASE |=> st_r.thr[0] == $past(reg_req.wdata))
    else $error("Threshold write did not reach the first detector.");
  chk_hv_wide_uv: assert property ( // RULE3
    !st_r.rng[RNG_HV_BIT] && det_level_mv[0] < 16'({8'h00, st_r.thr[0]} * WIDE_STEP_MV[0]) + WIDE_BASE_MV[0]
      |=> det_uv[0])
    else $error("High-voltage wide range failed to flag a low input.");
  chk_hv_fine_max: assert property (st_r.rng[RNG_HV_BIT] |-> thr_mv[0] <= HV_FINE_MAX_MV) // RULE4
    else $error("High-voltage fine threshold beyond its top.");
  chk_sec_unused: assert property (!st_r.rng[RNG_SEC_HI] |=> !det_uv[1]) // RULE23
    else $error("Second detector flagged in an unused range.");
  chk_pos_fine_ok: assert property ( // RULE9
    st_r.rng[RNG_POS_LO] && det_level_mv[2] >= 16'({8'h00, st_r.thr[2]} * FINE_STEP_MV[2]) + FINE_BASE_MV[2]
      |-> thr_mv[2] <= POS_FINE_MAX_MV ##1 !det_uv[2])
    else $error("Positive fine range flagged an input above threshold.");
  chk_mr_forces: assert property ( // RULE18
    !margin_hold && mr_act && st_r.mr_sel[0] && has_other[0] |=> po_act[0])
    else $error("Manual reset did not force its output active.");
  chk_mr_only: assert property ( // RULE20
    !has_other[0] |-> po_cond[0] == 1'b0)
    else $error("Output driven by manual reset alone.");
  chk_wd_first: assert property (s_first_expiry |=> watchdog_fault && st_r.wd_st == WD_NORMAL) // RULE16
    else $error("First watchdog period did not expire on time.");
  chk_wd_clear: assert property (s_clear_only |=> !watchdog_fault ##1 st_r.wd_cnt == 32'h0000_0001) // RULE15
    else $error("Watchdog clear did not restart the period.");
  chk_wr_block: assert property ( // RULE21
    nv_cfg.wr_block_en && po_act[nv_cfg.wr_block_po] |=> user_nv_wr_block)
    else $error("User memory writes not blocked by the selected output.");

endmodule // supply_supervisor

/* File: supply_supervisor_threshold_config_bench.sv */
`timescale 1ns/1ns
module supply_supervisor_threshold_config_bench;
  import supervisor_pkg::*;
  localparam logic [N_TMO-1:0][31:0] TMO = {32'h46, 32'h3c, 32'h32, 32'h28, 32'h1e, 32'h14, 32'h0a};
  localparam logic [N_WD-1:0][31:0] WDC = {32'h5a, 32'h50, 32'h46, 32'h3c, 32'h32, 32'h28, 32'h1e, 32'h14};
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req;
  logic [7:0] reg_rdata, rd;
  logic [N_DET-1:0][15:0] lvl = '1;
  logic [N_GPI-1:0] gpi_pin = '0;
  logic mr_n = 1'b1, margin_n = 1'b1;
  po_cfg_t [N_PO-1:0] po_cfg = '0;
  wd_cfg_t wd_cfg = '0;
  nv_cfg_t nv_cfg = '0;
  logic [N_PO-1:0] po_od_out, po_od_oe_n, po_active;
  logic [N_DET-1:0] det_uv;
  logic wd_fault, user_blk, cfg_blk;
  int error_cnt = 0, tests_run = 0, n;
  int fall [N_PO];
  logic [7:0] ah;
  initial forever #20 clk = ~clk;
  host_model host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  supply_supervisor #(.PO_TMO_CYC(TMO), .WD_CYC(WDC)) dut_u (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .det_level_mv(lvl), .gpi_pin(gpi_pin), .manual_reset_n(mr_n), .margin_n(margin_n),
    .po_cfg(po_cfg), .wd_cfg(wd_cfg), .nv_cfg(nv_cfg), .po_od_out(po_od_out), .po_od_oe_n(po_od_oe_n),
    .po_active(po_active), .det_uv(det_uv), .watchdog_fault(wd_fault), .user_nv_wr_block(user_blk),
    .cfg_nv_wr_block(cfg_blk));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Index 8 watches the watchdog fault, lower ones an output's active state.
  task automatic wait_until(input int w, input logic v, output int c);
    c = 0;
    while (((w == 8) ? wd_fault : po_active[w]) !== v) begin
      step(1);
      c++;
      if (c > 300) begin
        error_cnt++;
        $display("BAD wait on %0d expected %h seen timeout", w, v);
        print_verdict();
      end
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Threshold table: detector, range value, code, threshold in mV
  // ---------------------------------------------------------------
  logic [7:0] t_det [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h05, 8'h04};
  logic [7:0] t_rng [8] = '{8'h00, 8'h01, 8'h80, 8'hc0, 8'h00, 8'h04, 8'h10, 8'h00};
  logic [7:0] t_code [8] = '{8'hd6, 8'hff, 8'h3c, 8'h48, 8'he1, 8'hff, 8'h07, 8'h00};
  logic [15:0] t_mv [8] = '{16'h3390, 16'h1dc9, 16'h157c, 16'h0bea, 16'h157c, 16'h0bea, 16'h023a, 16'h03e8};
  initial begin
    for (int i = 0; i < N_PO; i++) begin
      po_cfg[i].tmo_sel = 3'(i);
      po_cfg[i].active_high = i[0];
      ah[i] = i[0];
    end
    step(12);
    rst = 1'b0;
    check("po_active_rst", po_active, 8'hff);
    check("det_uv_rst", det_uv, 8'h00);
    for (int i = 0; i < N_PO; i++) fall[i] = -1;
    for (int c = 1; c <= 90; c++) begin
      step(1);
      for (int i = 0; i < N_PO; i++) if (po_active[i] === 1'b0 && fall[i] < 0) fall[i] = c;
    end
    for (int i = 0; i < N_PO; i++) check("po_release", fall[i] >= TMO[i > 6 ? 6 : i] - 1 && fall[i] <= TMO[i > 6 ? 6 : i] + 3, 1);
    check("po_pin", po_od_oe_n, {24'h000000, ~ah});
    check("po_out", po_od_out, 8'h00);
    foreach (t_det[i]) begin
      host_u.read(i < 6 ? 8'(i) : (i == 6 ? ADDR_RANGE : ADDR_GPI_POL), rd);
      check("reg_rst", rd, 8'h00);
    end
    done("reset");
    for (int i = 0; i < N_DET; i++) host_u.write(8'(i), 8'h10 + 8'(i));
    host_u.write(ADDR_RANGE, 8'hff);
    host_u.write(8'h20, 8'haa);
    for (int i = 0; i < N_DET; i++) begin
      host_u.read(8'(i), rd);
      check("thr_reg", rd, 8'h10 + 8'(i));
    end
    host_u.read(ADDR_RANGE, rd);
    check("range_reg", rd, 8'hdf);
    host_u.read(8'h20, rd);
    check("unmapped", rd, RD_UNMAPPED);
    done("registers");
    foreach (t_det[i]) begin
      host_u.write(ADDR_RANGE, t_rng[i]);
      host_u.write(t_det[i], t_code[i]);
      step(3);
      lvl[t_det[i]] = t_mv[i] - 16'h0001;
      step(2);
      check("uv_below", det_uv[t_det[i]], 1'b1);
      lvl[t_det[i]] = t_mv[i];
      step(2);
      check("uv_at", det_uv[t_det[i]], 1'b0);
      lvl[t_det[i]] = 16'hffff;
    end
    host_u.write(ADDR_RANGE, 8'h00);
    lvl[1] = 16'h0000;
    step(4);
    check("uv_disabled", det_uv[1], 1'b0);
    lvl[1] = 16'hffff;
    done("thresholds");
    host_u.write(ADDR_MR_SEL, 8'h03);
    po_cfg[0].det_mask = 6'h04;
    mr_n = 1'b0;
    step(6);
    check("mr_assert", po_active[1:0], 2'b01);
    mr_n = 1'b1;
    wait_until(0, 1'b0, n);
    check("mr_release", n >= 10 && n <= 16, 1);
    done("manual_reset");
    po_cfg[2].det_mask = 6'h01;
    margin_n = 1'b0;
    step(3);
    lvl[0] = 16'h0000;
    step(6);
    check("margin_hold", {po_active[2], det_uv[0]}, 2'b01);
    margin_n = 1'b1;
    step(6);
    check("margin_off", po_active[2], 1'b1);
    lvl[0] = 16'hffff;
    done("margin");
    po_cfg[3].gpi_mask = 4'h1;
    step(6);
    check("gpi_low", po_active[3], 1'b1);
    host_u.write(ADDR_GPI_POL, 8'h03);
    wait_until(3, 1'b0, n);
    host_u.read(ADDR_GPI_POL, rd);
    check("gpi_pol", rd, 8'h03);
    done("logic_inputs");
    po_cfg[4] = '0;
    po_cfg[4].det_mask = 6'h01;
    wd_cfg = '{enable: 1'b1, clr_src: WD_CLR_GPI_AND_PO, gpi_idx: 2'h1, po_idx: 3'h4, init_sel: 3'h0, norm_sel: 3'h1};
    for (int m = 0; m < 3; m++) begin
      wd_cfg.clr_src = wd_clr_t'(m);
      wait_until(8, 1'b1, n);
      if (m == 0) check("wd_first", n >= 18 && n <= 26, 1);
      gpi_pin[1] = 1'b1;
      lvl[0] = 16'h0000;
      step(8);
      check("wd_clear", wd_fault, 1'b0);
      gpi_pin[1] = 1'b0;
      lvl[0] = 16'hffff;
      wait_until(4, 1'b0, n);
    end
    wd_cfg.clr_src = WD_CLR_GPI;
    wait_until(8, 1'b1, n);
    gpi_pin[1] = 1'b1;
    step(1);
    gpi_pin[1] = 1'b0;
    wait_until(8, 1'b0, n);
    po_cfg[6].wd_mask = 1'b1;
    wait_until(8, 1'b1, n);
    check("wd_normal", n >= 25 && n <= 33, 1);
    step(2);
    check("wd_mask", po_active[6], 1'b1);
    done("watchdog");
    nv_cfg = '{wr_block_en: 1'b1, wr_block_po: 3'h4, cfg_lock: 1'b1};
    po_cfg[5].po_mask = 8'h10;
    lvl[0] = 16'h0000;
    step(6);
    check("nv_block", {user_blk, cfg_blk}, 2'b11);
    check("po_chain", po_active[5], 1'b1);
    lvl[0] = 16'hffff;
    wait_until(4, 1'b0, n);
    step(3);
    check("nv_free", {user_blk, cfg_blk}, 2'b01);
    done("write_block");
    print_verdict();
  end
endmodule // supply_supervisor_threshold_config_bench
